// ### verilog/uart_frame_defines.svh
/*
  Constants for the serial port: register addresses, field positions,
  reset image and frame lengths.
  Assumes it is included by bare name from the design and the bench.
*/
`ifndef UART_FRAME_DEFINES_SVH
`define UART_FRAME_DEFINES_SVH

// Register addresses on the special-register port
`define SERIAL_PORT_CONTROL_ADDR 8'h98
`define SERIAL_DATA_BUFFER_ADDR 8'h99

// Reset image of serial_port_control (bit 6 reads as one)
`define SERIAL_PORT_CONTROL_RESET 8'h40
`define SERIAL_DATA_BUFFER_RESET 8'h00

// Field positions inside serial_port_control
`define FLD_FRAME_MODE 7
`define FLD_UNUSED 6
`define FLD_MULTIPROC 5
`define FLD_RX_ENABLE 4
`define FLD_TX_NINTH 3
`define FLD_RX_NINTH 2
`define FLD_TX_DONE 1
`define FLD_RX_DONE 0

// Frame shape: last data bit index, mode codes, line idle level
`define DATA_LAST_BIT 3'h7
`define MODE_8BIT 1'h0
`define MODE_9BIT 1'h1
`define LINE_IDLE 1'h1
`define RX_TIMER_TOP 8'hFF

`endif

// ### verilog/uart_frame_pkg.sv
/*
  Types for the serial port: state machine codes and the state record.
  Does not include the defines header and uses none of its names.
*/
package uart_frame_pkg;

  // Transmit sequencer, one-hot
  typedef enum logic [5:0] {
    TX_IDLE  = 6'h01,
    TX_WAIT  = 6'h02,
    TX_START = 6'h04,
    TX_DATA  = 6'h08,
    TX_NINTH = 6'h10,
    TX_STOP  = 6'h20
  } tx_e;

  // Receive sequencer, one-hot
  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_NINTH = 5'h08,
    RX_STOP  = 5'h10
  } rx_e;

  // Every flip-flop of the port
  typedef struct packed {
    logic mode_reg;
    logic mce_reg;
    logic ren_reg;
    logic tb8_reg;
    logic rb8_reg;
    logic ti_reg;
    logic ri_reg;
    logic [7:0] rbuf_reg;
    tx_e tx_state_reg;
    logic [7:0] tx_shift_reg;
    logic [2:0] tx_cnt_reg;
    logic tx_half_reg;
    logic tx_line_reg;
    rx_e rx_state_reg;
    logic [7:0] rx_shift_reg;
    logic [2:0] rx_cnt_reg;
    logic rx_ninth_reg;
    logic [7:0] rx_tmr_reg;
    logic rx_half_reg;
    logic rx_prev_reg;
    logic [7:0] rd_data_reg;
    logic irq_reg;
  } state_s;

endpackage

// ### verilog/uart_frame.sv
/*
  Full-duplex asynchronous serial port with 8-bit and 9-bit frames and
  ninth-bit address filtering, reached through two special registers.
  Assumes a CPU register port synchronous to CLOCK, a reload timer outside
  that supplies count ticks, its reload value and the transmit overflow
  pulse, and a serial input already synchronous to CLOCK.
*/
`timescale 1ns/1ns

module uart_frame (
  input wire logic CLOCK, // System clock, 20 MHz
  input wire logic RST, // Asynchronous reset, active high
  input wire logic [7:0] ADDR, // Special-register address
  input wire logic WR_EN, // Register write strobe
  input wire logic [7:0] WR_DATA, // Register write data
  input wire logic RD_EN, // Register read strobe
  output logic [7:0] RD_DATA, // Read data, one cycle after RD_EN
  input wire logic INT_ENABLE, // Port interrupt enable from the CPU
  output logic IRQ, // Port interrupt request
  input wire logic T1_TICK, // Reload timer count pulse
  input wire logic [7:0] T1_RELOAD, // Reload timer reload value
  input wire logic TX_OVF, // Transmit timer overflow pulse
  input wire logic SERIAL_IN_PIN, // Receive line
  output logic SERIAL_OUT_PIN // Transmit line
);

  `include "uart_frame_defines.svh"

  uart_frame_pkg::state_s st; // Present state
  uart_frame_pkg::state_s st_next; // Next state

  // Control register image as software sees it
  function automatic logic [7:0] control_image(
    input uart_frame_pkg::state_s s
  );
    control_image = {s.mode_reg, 1'h1, s.mce_reg, s.ren_reg,
                     s.tb8_reg, s.rb8_reg, s.ti_reg, s.ri_reg};
  endfunction

  logic wr_ctl; // Write to the control register
  logic wr_buf; // Write to the data buffer
  logic tx_tick; // One transmit bit time elapsed
  logic rx_ovf; // Receive timer copy overflow
  logic rx_tick; // Receive sample point, mid bit
  logic start_edge; // Falling edge on an idle enabled line
  logic stop_sample; // Stop bit being sampled now
  logic ninth_val; // Bit stored as received ninth bit
  logic accept; // Frame passes the load conditions

  // Decode of strobes and bit timing
  always_comb begin
    wr_ctl = WR_EN && (ADDR == `SERIAL_PORT_CONTROL_ADDR);
    wr_buf = WR_EN && (ADDR == `SERIAL_DATA_BUFFER_ADDR);
    tx_tick = TX_OVF && st.tx_half_reg;
    rx_ovf = T1_TICK && (st.rx_tmr_reg == `RX_TIMER_TOP);
    rx_tick = rx_ovf && !st.rx_half_reg;
    start_edge = st.ren_reg && (st.rx_state_reg == uart_frame_pkg::RX_IDLE)
                 && st.rx_prev_reg && !SERIAL_IN_PIN;
    stop_sample = rx_tick && (st.rx_state_reg == uart_frame_pkg::RX_STOP);
    // Stop bit in 8-bit mode, ninth data bit in 9-bit mode
    ninth_val = (st.mode_reg == `MODE_9BIT) ? st.rx_ninth_reg
                                            : SERIAL_IN_PIN;
    // A full buffer refuses the frame, which keeps the first byte
    accept = !st.ri_reg && (!st.mce_reg || ninth_val);
  end

  // Next-state logic for the whole port
  always_comb begin
    st_next = st;
    st_next.rx_prev_reg = SERIAL_IN_PIN;
    // Software writes land first so that hardware sets win below
    if (wr_ctl) begin
      st_next.mode_reg = WR_DATA[`FLD_FRAME_MODE];
      st_next.mce_reg = WR_DATA[`FLD_MULTIPROC];
      st_next.ren_reg = WR_DATA[`FLD_RX_ENABLE];
      st_next.tb8_reg = WR_DATA[`FLD_TX_NINTH];
      st_next.rb8_reg = WR_DATA[`FLD_RX_NINTH];
      st_next.ti_reg = WR_DATA[`FLD_TX_DONE];
      st_next.ri_reg = WR_DATA[`FLD_RX_DONE];
    end
    // Transmit timer divide by two
    if (TX_OVF) begin
      st_next.tx_half_reg = !st.tx_half_reg;
    end
    // Transmit sequencer; line changes only on whole bit times
    unique case (st.tx_state_reg)
      uart_frame_pkg::TX_IDLE: begin
        st_next.tx_line_reg = `LINE_IDLE;
        if (wr_buf) begin
          st_next.tx_shift_reg = WR_DATA;
          st_next.tx_state_reg = uart_frame_pkg::TX_WAIT;
        end
      end
      uart_frame_pkg::TX_WAIT: begin
        // Align the start bit to the shared bit clock
        if (tx_tick) begin
          st_next.tx_line_reg = 1'h0;
          st_next.tx_state_reg = uart_frame_pkg::TX_START;
        end
      end
      uart_frame_pkg::TX_START: begin
        if (tx_tick) begin
          st_next.tx_line_reg = st.tx_shift_reg[0];
          st_next.tx_shift_reg = {1'h0, st.tx_shift_reg[7:1]};
          st_next.tx_cnt_reg = 3'h0;
          st_next.tx_state_reg = uart_frame_pkg::TX_DATA;
        end
      end
      uart_frame_pkg::TX_DATA: begin
        if (tx_tick && st.tx_cnt_reg != `DATA_LAST_BIT) begin
          st_next.tx_line_reg = st.tx_shift_reg[0];
          st_next.tx_shift_reg = {1'h0, st.tx_shift_reg[7:1]};
          st_next.tx_cnt_reg = st.tx_cnt_reg + 3'h1;
        end else if (tx_tick && st.mode_reg == `MODE_9BIT) begin
          st_next.tx_line_reg = st.tb8_reg;
          st_next.tx_state_reg = uart_frame_pkg::TX_NINTH;
        end else if (tx_tick) begin
          st_next.tx_line_reg = `LINE_IDLE;
          st_next.ti_reg = 1'h1;
          st_next.tx_state_reg = uart_frame_pkg::TX_STOP;
        end
      end
      uart_frame_pkg::TX_NINTH: begin
        if (tx_tick) begin
          st_next.tx_line_reg = `LINE_IDLE;
          st_next.ti_reg = 1'h1;
          st_next.tx_state_reg = uart_frame_pkg::TX_STOP;
        end
      end
      uart_frame_pkg::TX_STOP: begin
        // Hold the stop bit one full bit time
        if (tx_tick) begin
          st_next.tx_state_reg = uart_frame_pkg::TX_IDLE;
        end
      end
    endcase
    // Receive timer copy: reloads on overflow or on a start edge
    if (start_edge) begin
      st_next.rx_tmr_reg = T1_RELOAD;
      st_next.rx_half_reg = 1'h0;
    end else if (rx_ovf) begin
      st_next.rx_tmr_reg = T1_RELOAD;
      st_next.rx_half_reg = !st.rx_half_reg;
    end else if (T1_TICK) begin
      st_next.rx_tmr_reg = st.rx_tmr_reg + 8'h01;
    end
    // Receive sequencer; samples fall at mid bit
    unique case (st.rx_state_reg)
      uart_frame_pkg::RX_IDLE: begin
        if (start_edge) begin
          st_next.rx_state_reg = uart_frame_pkg::RX_START;
        end
      end
      uart_frame_pkg::RX_START: begin
        // A start bit gone high by mid bit was a glitch
        if (rx_tick && !SERIAL_IN_PIN) begin
          st_next.rx_cnt_reg = 3'h0;
          st_next.rx_state_reg = uart_frame_pkg::RX_DATA;
        end else if (rx_tick) begin
          st_next.rx_state_reg = uart_frame_pkg::RX_IDLE;
        end
      end
      uart_frame_pkg::RX_DATA: begin
        if (rx_tick) begin
          st_next.rx_shift_reg = {SERIAL_IN_PIN, st.rx_shift_reg[7:1]};
          st_next.rx_cnt_reg = st.rx_cnt_reg + 3'h1;
          if (st.rx_cnt_reg == `DATA_LAST_BIT) begin
            st_next.rx_state_reg = (st.mode_reg == `MODE_9BIT) ?
              uart_frame_pkg::RX_NINTH : uart_frame_pkg::RX_STOP;
          end
        end
      end
      uart_frame_pkg::RX_NINTH: begin
        if (rx_tick) begin
          st_next.rx_ninth_reg = SERIAL_IN_PIN;
          st_next.rx_state_reg = uart_frame_pkg::RX_STOP;
        end
      end
      uart_frame_pkg::RX_STOP: begin
        if (rx_tick) begin
          st_next.rx_state_reg = uart_frame_pkg::RX_IDLE;
          if (accept) begin
            st_next.rbuf_reg = st.rx_shift_reg;
            st_next.rb8_reg = ninth_val;
            st_next.ri_reg = 1'h1;
          end
        end
      end
    endcase
    // Clearing the enable drops any frame in progress
    if (!st.ren_reg) begin
      st_next.rx_state_reg = uart_frame_pkg::RX_IDLE;
    end
    // Register read data, held between reads
    if (RD_EN) begin
      if (ADDR == `SERIAL_PORT_CONTROL_ADDR) begin
        st_next.rd_data_reg = control_image(st);
      end else if (ADDR == `SERIAL_DATA_BUFFER_ADDR) begin
        st_next.rd_data_reg = st.rbuf_reg;
      end else begin
        st_next.rd_data_reg = 8'h00;
      end
    end
    // Request follows the flags; no hardware clear of them exists
    st_next.irq_reg = INT_ENABLE && (st.ti_reg || st.ri_reg);
  end

  // State register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st <= '{mode_reg: 1'h0, mce_reg: 1'h0, ren_reg: 1'h0, tb8_reg: 1'h0,
              rb8_reg: 1'h0, ti_reg: 1'h0, ri_reg: 1'h0,
              rbuf_reg: `SERIAL_DATA_BUFFER_RESET,
              tx_state_reg: uart_frame_pkg::TX_IDLE, tx_shift_reg: 8'h00,
              tx_cnt_reg: 3'h0, tx_half_reg: 1'h0, tx_line_reg: `LINE_IDLE,
              rx_state_reg: uart_frame_pkg::RX_IDLE, rx_shift_reg: 8'h00,
              rx_cnt_reg: 3'h0, rx_ninth_reg: 1'h0, rx_tmr_reg: 8'h00,
              rx_half_reg: 1'h0, rx_prev_reg: `LINE_IDLE,
              rd_data_reg: 8'h00, irq_reg: 1'h0};
    end else begin
      st <= st_next;
    end
  end

  assign RD_DATA = st.rd_data_reg;
  assign IRQ = st.irq_reg;
  assign SERIAL_OUT_PIN = st.tx_line_reg;

  // Checks on the port's own behaviour
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  tx_idle_high_a: assert property (
    st.tx_state_reg == uart_frame_pkg::TX_IDLE |-> SERIAL_OUT_PIN)
    else $error("transmit line low while idle");

  tx_done_stop_a: assert property (
    $rose(st.tx_state_reg == uart_frame_pkg::TX_STOP)
    |-> st.ti_reg && SERIAL_OUT_PIN)
    else $error("transmit flag not set at stop bit");

  tx_ninth_bit_a: assert property (
    st.tx_state_reg == uart_frame_pkg::TX_NINTH |-> SERIAL_OUT_PIN ==
    st.tb8_reg || $past(st.tb8_reg) == SERIAL_OUT_PIN)
    else $error("ninth bit differs from control field");

  flag_hold_a: assert property (
    $fell(st.ti_reg) || $fell(st.ri_reg) |-> $past(wr_ctl))
    else $error("done flag cleared without software write");

  rx_load_a: assert property (
    stop_sample && accept |=> st.ri_reg && st.rbuf_reg ==
    $past(st.rx_shift_reg) && st.rb8_reg == $past(ninth_val))
    else $error("accepted frame not stored");

  rx_overrun_a: assert property (
    stop_sample && st.ri_reg |=> $stable(st.rbuf_reg))
    else $error("overrun replaced buffered byte");

  addr_filter_a: assert property (
    stop_sample && st.mce_reg && !ninth_val && !st.ri_reg && !wr_ctl
    |=> !st.ri_reg)
    else $error("unaddressed frame flagged");

  rx_disable_a: assert property (
    !st.ren_reg |=> st.rx_state_reg == uart_frame_pkg::RX_IDLE)
    else $error("receiver active while disabled");

  read_bit_six_a: assert property (
    RD_EN && ADDR == `SERIAL_PORT_CONTROL_ADDR |=> RD_DATA[`FLD_UNUSED])
    else $error("unused control bit read as zero");

  irq_follow_a: assert property (
    INT_ENABLE && (st.ti_reg || st.ri_reg) |=> IRQ)
    else $error("interrupt request missing");

  cover_tx_done_c: cover property (
    $rose(st.ti_reg) && st.mode_reg == `MODE_9BIT);
  cover_rx_accept_c: cover property (stop_sample && accept);
  cover_overrun_c: cover property (stop_sample && st.ri_reg);
  cover_filtered_c: cover property (stop_sample && st.mce_reg && !ninth_val);

endmodule // uart_frame

// ### dv/remote_uart.sv
/*
  Remote serial device on the far side of the port: sends frames on the
  receive line and captures frames from the transmit line.
  Assumes eight CLOCK cycles per bit, the rate the bench sets up.
*/
`timescale 1ns/1ns

module remote_uart (
  input wire logic clk, // Shared system clock
  input wire logic line_in, // Port transmit line
  output logic line_out // Port receive line
);

  // Idle high until a frame is sent
  initial begin
    line_out = 1'b1;
  end

  // Start, eight data LSB first, optional ninth, stop
  task automatic send(input logic [7:0] d, input logic n9,
                      input logic b9, input logic stp);
    logic [10:0] f;
    int n;
    f = {stp, b9, d, 1'b0};
    n = n9 ? 11 : 10;
    if (!n9) f[9] = stp;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (7) @(posedge clk);
    end
    @(posedge clk);
    line_out <= 1'b1;
  endtask

  // Bounded wait for the start edge, then sample mid-bit
  task automatic recv(input logic n9, output logic [8:0] d,
                      output logic stp);
    int k;
    d = 9'h000;
    k = 0;
    while (line_in !== 1'b0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      if (i < 8 || n9) begin
        repeat (8) @(posedge clk);
        d[i] = line_in;
      end
    end
    repeat (8) @(posedge clk);
    stp = line_in;
  endtask

endmodule // remote_uart

// ### dv/tb.sv
/*
  Self-checking bench: register image, transmit in both modes, receive
  acceptance, filtering, disable and overrun.
  Assumes the defines header on the include path and the remote model.
*/
`timescale 1ns/1ns
`include "uart_frame_defines.svh"

module tb;
  logic CLOCK, RST, WR_EN, RD_EN, INT_ENABLE, TX_OVF, IRQ;
  logic [7:0] ADDR, WR_DATA, RD_DATA;
  logic SERIAL_IN_PIN, SERIAL_OUT_PIN;
  logic [1:0] ovc; // Overflow prescaler
  logic [7:0] r, d, eb; // Read value, data, expected buffer
  logic [8:0] g9; // Captured frame
  logic m, mce, ren, b, a, tb8, stp;
  int n_fail, n_tests, cyc;

  uart_frame u_dut (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
    .WR_EN(WR_EN), .WR_DATA(WR_DATA), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
    .INT_ENABLE(INT_ENABLE), .IRQ(IRQ), .T1_TICK(1'b1),
    .T1_RELOAD(8'hFC), .TX_OVF(TX_OVF), .SERIAL_IN_PIN(SERIAL_IN_PIN),
    .SERIAL_OUT_PIN(SERIAL_OUT_PIN));

  remote_uart u_far (.clk(CLOCK), .line_in(SERIAL_OUT_PIN),
    .line_out(SERIAL_IN_PIN));

  // 50 ns clock
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  // Overflow every fourth cycle, so a bit lasts eight, matching the
  // receive copy reloaded with FC; also the hang guard
  always @(posedge CLOCK) begin
    ovc <= ovc + 2'h1;
    TX_OVF <= (ovc == 2'h3);
    cyc = cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      test_done();
    end
  end

  // Expected control image, bit 6 always one
  function automatic logic [7:0] ctl(logic m_i, logic mc, logic re,
      logic t8, logic r8, logic ti, logic ri);
    return {m_i, 1'b1, mc, re, t8, r8, ti, ri};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] gv);
    n_tests++;
    if (gv !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, gv);
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic gv);
    n_tests++;
    if (gv !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, e, gv);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] ad, input logic [7:0] dv);
    @(posedge CLOCK);
    ADDR <= ad;
    WR_DATA <= dv;
    WR_EN <= 1'b1;
    @(posedge CLOCK);
    WR_EN <= 1'b0;
  endtask

  // Read data lands at the edge that takes the strobe
  task automatic rd(input logic [7:0] ad);
    @(posedge CLOCK);
    ADDR <= ad;
    RD_EN <= 1'b1;
    @(posedge CLOCK);
    RD_EN <= 1'b0;
    #1 r = RD_DATA;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    {RST, WR_EN, RD_EN, INT_ENABLE, TX_OVF} = 5'h10;
    {ADDR, WR_DATA, ovc, eb} = 26'h0;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(32'h6FFD));
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    rd(`SERIAL_PORT_CONTROL_ADDR);
    chk("ctl_reset", 8'h40, r);
    rd(`SERIAL_DATA_BUFFER_ADDR);
    chk("buf_reset", 8'h00, r);
    rd(8'h9A);
    chk("unmapped", 8'h00, r);
    wr(`SERIAL_PORT_CONTROL_ADDR, 8'h00);
    rd(`SERIAL_PORT_CONTROL_ADDR);
    chk("bit6", 8'h40, r);
    chkb("idle", 1'b1, SERIAL_OUT_PIN);
    $display("test registers finished");
    // Transmit in both modes, interrupt enable toggled
    for (int i = 0; i < 4; i++) begin
      m = i[0];
      tb8 = 1'($urandom);
      d = 8'($urandom);
      INT_ENABLE <= i[1];
      wr(`SERIAL_PORT_CONTROL_ADDR, ctl(m, 0, 0, tb8, 0, 0, 0));
      wr(`SERIAL_DATA_BUFFER_ADDR, d);
      u_far.recv(m, g9, stp);
      chk("tx_data", d, g9[7:0]);
      chkb("tx_ninth", m & tb8, g9[8]);
      chkb("tx_stop", 1'b1, stp);
      rd(`SERIAL_PORT_CONTROL_ADDR);
      chk("tx_flag", ctl(m, 0, 0, tb8, 0, 1, 0), r);
      chkb("tx_irq", i[1], IRQ);
      repeat (8) @(posedge CLOCK);
    end
    $display("test transmit finished");
    // Receive: every mode, filter and bit value, then disabled
    INT_ENABLE <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      m = i[2];
      mce = i[1];
      b = i[0];
      ren = (i < 8);
      d = 8'($urandom);
      wr(`SERIAL_PORT_CONTROL_ADDR, ctl(m, mce, ren, 0, 0, 0, 0));
      repeat ($urandom % 8) @(posedge CLOCK);
      u_far.send(d, m, b, m ? ~b : b);
      a = ren && !(mce && !b);
      if (a) eb = d;
      rd(`SERIAL_DATA_BUFFER_ADDR);
      chk("rx_buf", eb, r);
      rd(`SERIAL_PORT_CONTROL_ADDR);
      chk("rx_ctl", ctl(m, mce, ren, 0, a & b, 0, a), r);
      chkb("rx_irq", a, IRQ);
    end
    $display("test receive finished");
    // Second frame while the first is unread
    wr(`SERIAL_PORT_CONTROL_ADDR, ctl(0, 0, 1, 0, 0, 0, 0));
    d = 8'($urandom);
    u_far.send(d, 0, 1, 1);
    u_far.send(~d, 0, 1, 1);
    repeat (100) @(posedge CLOCK);
    rd(`SERIAL_DATA_BUFFER_ADDR);
    chk("overrun_buf", d, r);
    rd(`SERIAL_PORT_CONTROL_ADDR);
    chk("overrun_ctl", ctl(0, 0, 1, 0, 1, 0, 1), r);
    $display("test overrun finished");
    test_done();
  end

endmodule // tb
